// *** lvd_cfg.svh ***
// offsets, field positions, reset values and filter counts of the voltage monitor
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// register byte offsets
`define CTRL_OFFS      8'h00
`define IRQC_OFFS      8'h04
`define GIE_OFFS       8'h08
`define STAT_OFFS      8'h0c
`define MASK_OFFS      8'h10

// control register fields
`define CTRL_TSEL_HI   7
`define CTRL_TSEL_LO   6
`define CTRL_DFLAG     5
`define CTRL_DEN       4
`define CTRL_BGEN      3
`define CTRL_VSEL_HI   2
`define CTRL_VSEL_LO   0

// request control fields
`define IRQC_FLAG      4
`define IRQC_EN        0
`define GIE_BIT        0

// status and mask fields
`define STAT_QUAL      0
`define STAT_DRISE     1
`define STAT_W         2

// reset values
`define CTRL_RST       8'h00
`define STAT_RST       2'h0

// filter lengths in slow oscillator edges
`define FILT_CNT_00    4'h2
`define FILT_CNT_01    4'h4
`define FILT_CNT_10    4'h8
`define FILT_CNT_11    4'h2

// external pin code of the threshold select
`define VSEL_EXT_PIN   3'h0

// bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// *** lvd_pkg.sv ***
// types shared by the voltage monitor modules
package lvd_pkg;
  typedef logic [7:0]  reg8_t;
  typedef logic [1:0]  axi_resp_t;
  typedef logic [1:0]  filt_sel_t;
  typedef logic [3:0]  filt_cnt_t;
endpackage : lvd_pkg

// *** lvd_filter_if.sv ***
// signals between the control logic and the duration filter
interface lvd_filter_if;
  import lvd_pkg::*;
  logic      tick;
  logic      det;
  filt_sel_t sel;
  logic      fire;

  modport ctl  (output tick, output det, output sel, input fire);
  modport filt (input tick, input det, input sel, output fire);
endinterface : lvd_filter_if

// *** lvd_filter.sv ***
// low-voltage duration filter counted in slow oscillator edges
`include "lvd_cfg.svh"
module lvd_filter
  import lvd_pkg::*;
(
  // clock and reset
  input wire logic   core_clk,
  input wire logic   nrst,
  // control side
  lvd_filter_if.filt fp
);
  filt_cnt_t cnt_r;
  logic      done_r;
  filt_cnt_t target;

  // selected duration
  always_comb begin
    case (fp.sel)
      2'h0:    target = `FILT_CNT_00;
      2'h1:    target = `FILT_CNT_01;
      2'h2:    target = `FILT_CNT_10;
      default: target = `FILT_CNT_11;
    endcase
  end

  // count while flag high, restart on drop, one pulse per episode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else if (!fp.det) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else if (fp.tick && !done_r) begin
      if (cnt_r + 4'h1 >= target) begin
        done_r <= 1'b1;
      end
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // pulse in the cycle the count is reached
  assign fp.fire = fp.det && fp.tick && !done_r && (cnt_r + 4'h1 >= target);
endmodule : lvd_filter

// *** lvd_monitor.sv ***
// low-voltage monitor control: register file, detection flag, filter and request
`include "lvd_cfg.svh"
module lvd_monitor
  import lvd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  // axi4-lite write response
  output axi_resp_t              s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  // axi4-lite read data
  output logic [31:0]            s_rdata,
  output axi_resp_t              s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // analog comparator and slow oscillator
  input  wire logic              comparator_low,
  input  wire logic              slow_osc_clk,
  output logic                   detector_on,
  output logic                   monitor_pin_select,
  output logic [2:0]             threshold_select,
  output logic                   bandgap_on,
  // power mode and reset block
  input  wire logic              sleep_mode,
  input  wire logic              idle_mode,
  input  wire logic              lvr_enable,
  // interrupt and wake
  output logic                   irq,
  output logic                   idle_wake
);

  // bus state
  logic                 awready_r;
  logic                 wready_r;
  logic                 aw_hold_r;
  logic                 w_hold_r;
  logic [ADDR_W-1:0]    aw_addr_r;
  logic [31:0]          w_data_r;
  logic                 w_strb0_r;
  logic                 bvalid_r;
  axi_resp_t            bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [31:0]          rdata_r;
  axi_resp_t            rresp_r;
  // register state
  reg8_t                ctrl_r;
  logic                 irq_flag_r;
  logic                 irq_en_r;
  logic                 gie_r;
  logic [`STAT_W-1:0]   stat_r;
  logic [`STAT_W-1:0]   mask_r;
  // synchronisers and detection
  logic                 cmp_meta_r;
  logic                 cmp_sync_r;
  logic                 osc_meta_r;
  logic                 osc_sync_r;
  logic                 osc_prev_r;
  logic                 det_flag_r;
  // outputs toward the analog side, interrupt and wake
  logic                 det_on_r;
  logic                 pin_sel_r;
  logic [2:0]           vsel_r;
  logic                 bg_on_r;
  logic                 irq_r;
  logic                 wake_r;
  // combinational terms
  logic                 aw_fire;
  logic                 w_fire;
  logic                 ar_fire;
  logic                 do_wr;
  logic                 aw_hold_nxt;
  logic                 w_hold_nxt;
  logic                 rvalid_nxt;
  logic                 wr_ok;
  logic                 wr_ctrl;
  logic                 wr_irqc;
  logic                 wr_gie;
  logic                 wr_stat;
  logic                 wr_mask;
  logic                 det_active;
  logic                 osc_tick;
  logic                 qual_fire;
  logic                 det_rise;
  logic [31:0]          rd_data;
  logic                 rd_ok;
  lvd_filter_if fif ();

  // write channel: address and data taken in either order
  assign aw_fire     = s_awvalid && awready_r;
  assign w_fire      = s_wvalid && wready_r;
  assign do_wr       = aw_hold_r && w_hold_r && !bvalid_r;
  assign aw_hold_nxt = do_wr ? 1'b0 : (aw_hold_r || aw_fire);
  assign w_hold_nxt  = do_wr ? 1'b0 : (w_hold_r || w_fire);
  // hold address and data until both are present
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0;
      w_strb0_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= !aw_hold_nxt;
      wready_r  <= !w_hold_nxt;
      if (aw_fire) begin
        aw_addr_r <= s_awaddr;
      end
      if (w_fire) begin
        w_data_r  <= s_wdata;
        w_strb0_r <= s_wstrb[0];
      end
    end
  end

  // write decode, registers are the low byte of aligned words
  always_comb begin
    wr_ctrl = 1'b0;
    wr_irqc = 1'b0;
    wr_gie  = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    wr_ok   = 1'b1;
    case (aw_addr_r[7:0])
      `CTRL_OFFS: wr_ctrl = do_wr && w_strb0_r;
      `IRQC_OFFS: wr_irqc = do_wr && w_strb0_r;
      `GIE_OFFS:  wr_gie  = do_wr && w_strb0_r;
      `STAT_OFFS: wr_stat = do_wr && w_strb0_r;
      `MASK_OFFS: wr_mask = do_wr && w_strb0_r;
      default:    wr_ok   = 1'b0;
    endcase
  end

  // write response after both halves
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_r && s_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel
  assign ar_fire    = s_arvalid && arready_r;
  assign rvalid_nxt = ar_fire || (rvalid_r && !s_rready);
  // read mux, bits above the register read as zero
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    case (s_araddr[7:0])
      `CTRL_OFFS: begin
        rd_data[7:0]         = ctrl_r;
        rd_data[`CTRL_DFLAG] = det_flag_r;
      end
      `IRQC_OFFS: begin
        rd_data[`IRQC_FLAG] = irq_flag_r;
        rd_data[`IRQC_EN]   = irq_en_r;
      end
      `GIE_OFFS:  rd_data[`GIE_BIT] = gie_r;
      `STAT_OFFS: rd_data[`STAT_W-1:0] = stat_r;
      `MASK_OFFS: rd_data[`STAT_W-1:0] = mask_r;
      default:    rd_ok = 1'b0;
    endcase
  end

  // read data held until taken
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= `RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_fire) begin
        rdata_r <= rd_data;
        rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // control register, detection flag bit is not stored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r                 <= w_data_r[7:0];
      ctrl_r[`CTRL_DFLAG]    <= 1'b0;
    end
  end

  // request control and global enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_r <= 1'b0;
      gie_r    <= 1'b0;
    end else begin
      if (wr_irqc) begin
        irq_en_r <= w_data_r[`IRQC_EN];
      end
      if (wr_gie) begin
        gie_r <= w_data_r[`GIE_BIT];
      end
    end
  end

  // synchronisers for comparator and slow oscillator
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      cmp_meta_r <= comparator_low;
      cmp_sync_r <= cmp_meta_r;
      osc_meta_r <= slow_osc_clk;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end
  assign osc_tick   = osc_sync_r && !osc_prev_r;
  assign det_active = ctrl_r[`CTRL_DEN] && !sleep_mode;
  // detection flag, low while detector is off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      det_flag_r <= 1'b0;
    end else begin
      det_flag_r <= det_active && cmp_sync_r;
    end
  end

  assign det_rise = det_active && cmp_sync_r && !det_flag_r;

  // duration filter
  assign fif.tick = osc_tick;
  assign fif.det  = det_flag_r;
  assign fif.sel  = ctrl_r[`CTRL_TSEL_HI:`CTRL_TSEL_LO];
  assign qual_fire = fif.fire;
  lvd_filter u_filter (
    .core_clk (core_clk),
    .nrst     (nrst),
    .fp       (fif.filt)
  );
  // request flag, hardware set wins over a software write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_flag_r <= 1'b0;
    end else if (qual_fire) begin
      irq_flag_r <= 1'b1;
    end else if (wr_irqc) begin
      irq_flag_r <= w_data_r[`IRQC_FLAG];
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= `STAT_RST;
    end else begin
      for (int i = 0; i < `STAT_W; i++) begin
        if (wr_stat && w_data_r[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
      if (qual_fire) begin
        stat_r[`STAT_QUAL] <= 1'b1;
      end
      if (det_rise) begin
        stat_r[`STAT_DRISE] <= 1'b1;
      end
    end
  end

  // status mask
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_r <= `STAT_RST;
    end else if (wr_mask) begin
      mask_r <= w_data_r[`STAT_W-1:0];
    end
  end

  // interrupt and idle wake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= gie_r && ((irq_flag_r && irq_en_r) || |(stat_r & mask_r));
      wake_r <= idle_mode && qual_fire && !irq_flag_r;
    end
  end

  // analog controls
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      det_on_r  <= 1'b0;
      pin_sel_r <= 1'b1;
      vsel_r    <= `VSEL_EXT_PIN;
      bg_on_r   <= 1'b0;
    end else begin
      det_on_r  <= det_active;
      pin_sel_r <= ctrl_r[`CTRL_VSEL_HI:`CTRL_VSEL_LO] == `VSEL_EXT_PIN;
      vsel_r    <= ctrl_r[`CTRL_VSEL_HI:`CTRL_VSEL_LO];
      bg_on_r   <= ctrl_r[`CTRL_DEN] || lvr_enable || ctrl_r[`CTRL_BGEN];
    end
  end
  // port drivers
  assign s_awready          = awready_r;
  assign s_wready           = wready_r;
  assign s_bvalid           = bvalid_r;
  assign s_bresp            = bresp_r;
  assign s_arready          = arready_r;
  assign s_rvalid           = rvalid_r;
  assign s_rdata            = rdata_r;
  assign s_rresp            = rresp_r;
  assign detector_on        = det_on_r;
  assign monitor_pin_select = pin_sel_r;
  assign threshold_select   = vsel_r;
  assign bandgap_on         = bg_on_r;
  assign irq                = irq_r;
  assign idle_wake          = wake_r;
endmodule : lvd_monitor

// *** lvd_bus_monitor.sv ***
// concurrent checks on the voltage monitor ports
module lvd_bus_monitor
  import lvd_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // register bus
  input wire logic       s_awvalid,
  input wire logic       s_awready,
  input wire logic       s_wvalid,
  input wire logic       s_wready,
  input wire logic       s_bvalid,
  input wire logic       s_arvalid,
  input wire logic       s_arready,
  input wire logic       s_rvalid,
  input wire logic       s_rready,
  // detector control
  input wire logic       detector_on,
  input wire logic       monitor_pin_select,
  input wire logic [2:0] threshold_select,
  input wire logic       bandgap_on,
  // power mode and wake
  input wire logic       sleep_mode,
  input wire logic       idle_mode,
  input wire logic       lvr_enable,
  input wire logic       idle_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // comparator input follows the threshold code
  AST_PIN_SEL: assert property (threshold_select == 3'h0 |-> monitor_pin_select)
    else $error("pin compare not selected for code zero");
  AST_SUPPLY_SEL: assert property (threshold_select != 3'h0 |-> !monitor_pin_select)
    else $error("pin compare selected for a supply code");
  // power of detector and bandgap
  AST_SLEEP_OFF: assert property (sleep_mode |=> !detector_on)
    else $error("detector powered in sleep");
  AST_BG_LVR: assert property (lvr_enable |=> bandgap_on)
    else $error("bandgap off while reset monitor enabled");
  AST_BG_DET: assert property (detector_on |-> bandgap_on)
    else $error("bandgap off while detector on");
  // wake pulse
  AST_WAKE_ONE: assert property (idle_wake |=> !idle_wake)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_IDLE: assert property (idle_wake |-> $past(idle_mode))
    else $error("wake pulse outside idle");
  // bus answer timing
  AST_WR_LAT: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> !s_bvalid ##1 s_bvalid)
    else $error("write answer not two cycles after take");
  AST_RD_LAT: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer not one cycle after take");
  AST_RD_DROP: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read answer held after take");
  AST_AR_BLOCK: assert property (s_rvalid |-> !s_arready)
    else $error("read address accepted while answer pending");
endmodule : lvd_bus_monitor

// *** lvd_monitor_tb.sv ***
// self-checking bench for the low-voltage monitor
`include "lvd_cfg.svh"
module lvd_monitor_tb
  import lvd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        nrst;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  axi_resp_t   s_bresp, s_rresp, resp;
  logic        comparator_low, slow_osc_clk, detector_on, monitor_pin_select, bandgap_on;
  logic [2:0]  threshold_select;
  logic        sleep_mode, idle_mode, lvr_enable, irq, idle_wake;
  int          failures = 0, checked = 0, cycles = 0, wakes = 0;
  int          ticks_tab [4] = '{2, 4, 8, 2};

  always #2ns core_clk = ~core_clk;

  lvd_monitor #(.ADDR_W(8)) u_lvd_monitor (
    .core_clk(core_clk), .nrst(nrst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .comparator_low(comparator_low), .slow_osc_clk(slow_osc_clk), .detector_on(detector_on),
    .monitor_pin_select(monitor_pin_select), .threshold_select(threshold_select),
    .bandgap_on(bandgap_on), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .lvr_enable(lvr_enable), .irq(irq), .idle_wake(idle_wake)
  );

  // cycle ceiling and wake pulse counter
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (idle_wake === 1'b1) wakes <= wakes + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  // count one comparison and report a mismatch
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bus write, both channels offered together, pins settle after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_awready) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : wr

  // bus read and compare
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge core_clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_rvalid !== 1'b1);
    rd = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
    check(what, rd, exp);
  endtask : rd_chk

  // slow oscillator periods of eight core cycles
  task automatic ticks(input int n);
    repeat (n) begin
      slow_osc_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      slow_osc_clk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : ticks

  // low-voltage stretch of n ticks, optionally ended by a rise
  task automatic run_low(input int n, input logic drop);
    comparator_low <= 1'b1;
    repeat (6) @(posedge core_clk);
    ticks(n);
    if (drop) begin
      comparator_low <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask : run_low

  // verdict and end of run
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    nrst = 1'b0;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
    {comparator_low, slow_osc_clk, sleep_mode, idle_mode, lvr_enable} = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("pin_select", {31'h0, monitor_pin_select}, 32'h1);
    check("detector_on", {31'h0, detector_on}, 32'h0);
    rd_chk("ctrl_reset", `CTRL_OFFS, 32'h0);
    rd_chk("unmapped_rd", 8'h14, 32'h0);
    check("rresp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(8'h14, 32'hff);
    check("bresp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
    $display("test reset and map done");
    for (int c = 0; c < 8; c++) begin
      wr(`CTRL_OFFS, 32'(c));
      check("threshold", {29'h0, threshold_select}, 32'(c));
      check("pin_select", {31'h0, monitor_pin_select}, {31'h0, c == 0});
      rd_chk("ctrl_code", `CTRL_OFFS, 32'(c));
    end
    s_wstrb <= 4'he;
    wr(`CTRL_OFFS, 32'h0);
    check("bresp_strb", {30'h0, resp}, {30'h0, `RESP_OKAY});
    rd_chk("ctrl_strb", `CTRL_OFFS, 32'h7);
    s_wstrb <= 4'hf;
    $display("test threshold codes done");
    wr(`CTRL_OFFS, 32'h30);
    rd_chk("ctrl_ro", `CTRL_OFFS, 32'h10);
    check("detector_on", {31'h0, detector_on}, 32'h1);
    check("bandgap_det", {31'h0, bandgap_on}, 32'h1);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("sleep_off", {31'h0, detector_on}, 32'h0);
    sleep_mode <= 1'b0;
    repeat (8) @(posedge core_clk);
    comparator_low <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk("flag_low", `CTRL_OFFS, 32'h30);
    comparator_low <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd_chk("flag_clear", `CTRL_OFFS, 32'h10);
    wr(`CTRL_OFFS, 32'h08);
    check("det_off", {31'h0, detector_on}, 32'h0);
    check("bandgap_bit", {31'h0, bandgap_on}, 32'h1);
    wr(`CTRL_OFFS, 32'h00);
    lvr_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("bandgap_lvr", {31'h0, bandgap_on}, 32'h1);
    lvr_enable <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("bandgap_none", {31'h0, bandgap_on}, 32'h0);
    $display("test enable and flag done");
    wr(`GIE_OFFS, 32'h1);
    idle_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`CTRL_OFFS, {24'h0, 2'(c), 6'h10});
      wr(`IRQC_OFFS, 32'h01);
      wr(`STAT_OFFS, 32'h03);
      run_low(ticks_tab[c] - 1, 1'b1);
      run_low(ticks_tab[c] - 1, 1'b0);
      rd_chk("flag_early", `IRQC_OFFS, 32'h01);
      ticks(1);
      rd_chk("flag_set", `IRQC_OFFS, 32'h11);
      check("irq_on", {31'h0, irq}, 32'h1);
      comparator_low <= 1'b0;
    end
    check("wakes", 32'(wakes), 32'h4);
    wr(`GIE_OFFS, 32'h0);
    check("irq_global", {31'h0, irq}, 32'h0);
    wr(`IRQC_OFFS, 32'h11);
    wr(`STAT_OFFS, 32'h03);
    run_low(2, 1'b1);
    check("wakes_preset", 32'(wakes), 32'h4);
    $display("test filter and wake done");
    wr(`GIE_OFFS, 32'h1);
    wr(`IRQC_OFFS, 32'h10);
    check("irq_disabled", {31'h0, irq}, 32'h0);
    wr(`MASK_OFFS, 32'h01);
    check("irq_status", {31'h0, irq}, 32'h1);
    wr(`STAT_OFFS, 32'h01);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    rd_chk("status", `STAT_OFFS, 32'h02);
    idle_mode <= 1'b0;
    $display("test interrupt done");
    complete_run();
  end
endmodule : lvd_monitor_tb

bind lvd_monitor lvd_bus_monitor u_lvd_bus_monitor (
  .core_clk(core_clk), .nrst(nrst), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready), .detector_on(detector_on),
  .monitor_pin_select(monitor_pin_select), .threshold_select(threshold_select),
  .bandgap_on(bandgap_on), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
  .lvr_enable(lvr_enable), .idle_wake(idle_wake)
);
